// [fault_input_detect.sv]
// constants for the output-disable unit and the per-input fault detector
//
// Functional notes
// - nine active-low request inputs, each edge or low-level triggered
// - sampling clock is peripheral clock /1, /2, /4, /8, /16 or /128
// - low level accepted after 4, 8 or 16 consecutive low samples
// - a detected request condition disables the target outputs
// - main oscillator stop report disables the target outputs
// - both members of a timer complementary pair active disables outputs
// - both A and B of a PWM channel active disables outputs
// - analog comparator detection disables the target outputs
// - software can force the disable through its own request register
// - interrupt requests for input sampling and output overlap faults
// - targets are the listed timer and PWM timer output pins
// - four-bit mode per input: 0 edge, 1-6 low sampling, rest prohibited
// - per-input sticky flag, cleared by zero write after reading one
package poe_pkg;
   // ----------------------------------------------------------------
   // register map (byte offsets on the plain register port)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] REG_MODE_LO = 8'h00;
   localparam logic [7:0] REG_MODE_HI = 8'h04;
   localparam logic [7:0] REG_COUNT_SEL = 8'h08;
   localparam logic [7:0] REG_FLAGS = 8'h0C;
   localparam logic [7:0] REG_ENABLE = 8'h10;
   localparam logic [7:0] REG_SOFT = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   // ----------------------------------------------------------------
   // sources and flag positions
   // ----------------------------------------------------------------
   localparam int N_REQ = 9;
   localparam int N_FLAGS = 13;
   localparam int FLAG_OSC = 9;
   localparam int FLAG_CMP = 10;
   localparam int FLAG_MTU_OVL = 11;
   localparam int FLAG_PWM_OVL = 12;
   localparam int EN_IRQ_IN = 13;
   localparam int EN_IRQ_OVL = 14;
   localparam int EN_W = 15;
   localparam logic [14:0] ENABLE_RESET = 15'h1FFF;
   localparam int STAT_DISABLED = 9;
   localparam int STAT_OSC = 10;
   // ----------------------------------------------------------------
   // detection modes, sample counts, prescaler masks
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_EDGE = 4'h0;
   localparam logic [3:0] MODE_DIV8 = 4'h1;
   localparam logic [3:0] MODE_DIV16 = 4'h2;
   localparam logic [3:0] MODE_DIV128 = 4'h3;
   localparam logic [3:0] MODE_DIV1 = 4'h4;
   localparam logic [3:0] MODE_DIV2 = 4'h5;
   localparam logic [3:0] MODE_DIV4 = 4'h6;
   localparam logic [1:0] CNT_SEL_16 = 2'h0;
   localparam logic [1:0] CNT_SEL_8 = 2'h1;
   localparam logic [1:0] CNT_SEL_4 = 2'h2;
   localparam logic [4:0] SAMPLES_16 = 5'h10;
   localparam logic [4:0] SAMPLES_8 = 5'h08;
   localparam logic [4:0] SAMPLES_4 = 5'h04;
   localparam logic [6:0] MASK_DIV1 = 7'h00;
   localparam logic [6:0] MASK_DIV2 = 7'h01;
   localparam logic [6:0] MASK_DIV4 = 7'h03;
   localparam logic [6:0] MASK_DIV8 = 7'h07;
   localparam logic [6:0] MASK_DIV16 = 7'h0F;
   localparam logic [6:0] MASK_DIV128 = 7'h7F;

   // low-level sampling mode, prohibited codes excluded
   function automatic logic is_low_mode(input logic [3:0] mode);
      is_low_mode = (mode >= MODE_DIV8) && (mode <= MODE_DIV4);
   endfunction : is_low_mode

   // sampling strobe from the shared prescaler
   function automatic logic sample_tick(input logic [3:0] mode,
                                        input logic [6:0] pre);
      logic [6:0] mask;
      mask = MASK_DIV128;
      case (mode)
         MODE_DIV1: mask = MASK_DIV1;
         MODE_DIV2: mask = MASK_DIV2;
         MODE_DIV4: mask = MASK_DIV4;
         MODE_DIV8: mask = MASK_DIV8;
         MODE_DIV16: mask = MASK_DIV16;
         default: mask = MASK_DIV128;
      endcase
      sample_tick = is_low_mode(mode) && ((pre & mask) == MASK_DIV1);
   endfunction : sample_tick

   // consecutive low samples needed
   function automatic logic [4:0] sample_goal(input logic [1:0] sel);
      case (sel)
         CNT_SEL_8: sample_goal = SAMPLES_8;
         CNT_SEL_4: sample_goal = SAMPLES_4;
         default: sample_goal = SAMPLES_16;
      endcase
   endfunction : sample_goal

   typedef enum logic [1:0]
   {
      ST_WATCH = 2'b00,
      ST_LOW = 2'b01,
      ST_HELD = 2'b10
   } det_state_t;
endpackage : poe_pkg

`timescale 1ns/1ps
module fault_input_detect
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // request pin, active low
   input wire logic pin_n,
   // configuration
   input wire logic [3:0] mode,
   input wire logic [1:0] count_sel,
   input wire logic [6:0] prescale,
   // one-cycle detection pulse
   output logic detect_r
);
   poe_pkg::det_state_t state_r;
   logic prev_r;
   logic [4:0] run_r;
   logic tick;
   logic [4:0] goal;
   logic [4:0] run_nxt;

   assign tick = poe_pkg::sample_tick(mode, prescale);
   assign goal = poe_pkg::sample_goal(count_sel);
   assign run_nxt = run_r + 5'h01;

   // previous pin level for edge detection
   always_ff @(posedge clock)
   begin
      if (rst)
         prev_r <= 1'b1;
      else
         prev_r <= pin_n;
   end

   // watch / count low samples / wait for release
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_r <= poe_pkg::ST_WATCH;
         run_r <= 5'h00;
         detect_r <= 1'b0;
      end
      else
      begin
         detect_r <= 1'b0;
         case (state_r)
            poe_pkg::ST_WATCH:
            begin
               run_r <= 5'h00;
               if (mode == poe_pkg::MODE_EDGE && prev_r && !pin_n)
                  detect_r <= 1'b1;
               else if (tick && !pin_n)
               begin
                  run_r <= 5'h01;
                  state_r <= poe_pkg::ST_LOW;
               end
            end
            poe_pkg::ST_LOW:
            begin
               // a change to edge or a prohibited mode mid-count abandons the run
               if (!poe_pkg::is_low_mode(mode) || pin_n)
                  state_r <= poe_pkg::ST_WATCH;
               else if (tick)
               begin
                  run_r <= run_nxt;
                  if (run_nxt == goal)
                  begin
                     detect_r <= 1'b1;
                     state_r <= poe_pkg::ST_HELD;
                  end
               end
            end
            poe_pkg::ST_HELD:
            begin
               // one report per low episode; the flag is sticky anyway
               if (pin_n)
                  state_r <= poe_pkg::ST_WATCH;
            end
            default: state_r <= poe_pkg::ST_WATCH;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_edge_detect: assert property (@(posedge clock)
      disable iff (rst)
      (mode == poe_pkg::MODE_EDGE && $past(mode) == poe_pkg::MODE_EDGE
       && $fell(pin_n) && state_r == poe_pkg::ST_WATCH) |=> detect_r)
      else $error("falling edge not reported");
   chk_low_count: assert property (@(posedge clock)
      disable iff (rst) (detect_r && poe_pkg::is_low_mode(mode))
      |-> run_r == goal)
      else $error("low level accepted with wrong sample count");
   chk_bad_mode: assert property (@(posedge clock)
      disable iff (rst)
      (mode > poe_pkg::MODE_DIV4 && $past(mode) > poe_pkg::MODE_DIV4)
      |-> !detect_r)
      else $error("prohibited mode produced a detection");
endmodule : fault_input_detect

// [port_output_disable_control.sv]
// emergency output-disable unit with plain register port
`timescale 1ns/1ps
module port_output_disable_control
#(
   parameter int MTU_PAIRS = 6,
   parameter int PWM_CH = 9,
   parameter int MTU_PINS = 20,
   parameter int PWM_PINS = 20
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port
   input wire logic [poe_pkg::ADDR_W-1:0] addr,
   input wire logic [poe_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [poe_pkg::DATA_W-1:0] rdata_r,
   // fault request pins, active low
   input wire logic fault_request_in_0_n,
   input wire logic fault_request_in_4_n,
   input wire logic fault_request_in_8_n,
   input wire logic fault_request_in_9_n,
   input wire logic fault_request_in_10_n,
   input wire logic fault_request_in_11_n,
   input wire logic fault_request_in_12_n,
   input wire logic fault_request_in_13_n,
   input wire logic fault_request_in_14_n,
   // other fault sources
   input wire logic osc_stop_detected,
   input wire logic analog_comparator_unit_detect,
   // timer outputs watched for overlap, active high
   input wire logic [MTU_PAIRS-1:0] mtu_pair_a,
   input wire logic [MTU_PAIRS-1:0] mtu_pair_b,
   input wire logic [PWM_CH-1:0] pwm_out_a,
   input wire logic [PWM_CH-1:0] pwm_out_b,
   // pin release to general-purpose port, high = disabled
   output logic [MTU_PINS-1:0] mtu_pin_release_r,
   output logic [PWM_PINS-1:0] pwm_pin_release_r,
   // interrupt requests
   output logic input_irq_r,
   output logic overlap_irq_r
);
   localparam int NF = poe_pkg::N_FLAGS;
   localparam int NR = poe_pkg::N_REQ;

   // ----------------------------------------------------------------
   // registers and wiring
   // ----------------------------------------------------------------
   logic [NR-1:0] pins_n;
   logic [NR-1:0] det;
   logic [6:0] prescale_r;
   logic [4*NR-1:0] mode_r;
   logic [2*NR-1:0] cnt_sel_r;
   logic [NF-1:0] flags_r;
   logic [NF-1:0] seen_r;
   logic [poe_pkg::EN_W-1:0] enable_r;
   logic software_disable_request_reg_r;
   logic [NF-1:0] set_ev;
   logic [NF-1:0] clr_ok;
   logic [NF-1:0] clr_req;
   logic wr_flags;
   logic rd_flags;
   logic mtu_off_nxt;
   logic pwm_off_nxt;
   logic [poe_pkg::DATA_W-1:0] rdata_nxt;

   assign pins_n = {fault_request_in_14_n, fault_request_in_13_n,
                    fault_request_in_12_n, fault_request_in_11_n,
                    fault_request_in_10_n, fault_request_in_9_n,
                    fault_request_in_8_n, fault_request_in_4_n,
                    fault_request_in_0_n};
   assign wr_flags = wr && (addr == poe_pkg::REG_FLAGS);
   assign rd_flags = rd && (addr == poe_pkg::REG_FLAGS);

   // shared free-running prescaler for the sampling clocks
   always_ff @(posedge clock)
   begin
      if (rst)
         prescale_r <= 7'h00;
      else
         prescale_r <= prescale_r + 7'h01;
   end

   // ----------------------------------------------------------------
   // per-input detectors
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NR; i++)
   begin : g_req
      fault_input_detect u_det
      (
         .clock(clock),
         .rst(rst),
         .pin_n(pins_n[i]),
         .mode(mode_r[4*i +: 4]),
         .count_sel(cnt_sel_r[2*i +: 2]),
         .prescale(prescale_r),
         .detect_r(det[i])
      );
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // mode and sample-count fields, reset to edge detection
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         mode_r <= '0;
         cnt_sel_r <= '0;
      end
      else if (wr)
      begin
         case (addr)
            poe_pkg::REG_MODE_LO: mode_r[31:0] <= wdata;
            poe_pkg::REG_MODE_HI: mode_r[4*NR-1:32] <= wdata[3:0];
            poe_pkg::REG_COUNT_SEL: cnt_sel_r <= wdata[2*NR-1:0];
            default: ;
         endcase
      end
   end

   // source and interrupt enables
   always_ff @(posedge clock)
   begin
      if (rst)
         enable_r <= poe_pkg::ENABLE_RESET;
      else if (wr && addr == poe_pkg::REG_ENABLE)
         enable_r <= wdata[poe_pkg::EN_W-1:0];
   end

   // software request, held until software writes zero
   always_ff @(posedge clock)
   begin
      if (rst)
         software_disable_request_reg_r <= 1'b0;
      else if (wr && addr == poe_pkg::REG_SOFT)
         software_disable_request_reg_r <= wdata[0];
   end

   // ----------------------------------------------------------------
   // sticky flags
   // ----------------------------------------------------------------
   // events from every source in one vector
   always_comb
   begin
      set_ev = '0;
      set_ev[NR-1:0] = det;
      set_ev[poe_pkg::FLAG_OSC] = osc_stop_detected;
      set_ev[poe_pkg::FLAG_CMP] = analog_comparator_unit_detect;
      set_ev[poe_pkg::FLAG_MTU_OVL] = |(mtu_pair_a & mtu_pair_b);
      set_ev[poe_pkg::FLAG_PWM_OVL] = |(pwm_out_a & pwm_out_b);
   end

   // a low-level flag may only clear while its pin is back high
   always_comb
   begin
      clr_ok = '1;
      for (int i = 0; i < NR; i++)
      begin
         if (poe_pkg::is_low_mode(mode_r[4*i +: 4]) && !pins_n[i])
            clr_ok[i] = 1'b0;
      end
      clr_req = {NF{wr_flags}} & ~wdata[NF-1:0] & seen_r & clr_ok;
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clock)
   begin
      if (rst)
         flags_r <= '0;
      else
         flags_r <= (flags_r & ~clr_req) | set_ev;
   end

   // bits read as one arm the zero-write clear; any flag write disarms
   always_ff @(posedge clock)
   begin
      if (rst)
         seen_r <= '0;
      else if (wr_flags)
         seen_r <= '0;
      else if (rd_flags)
         seen_r <= seen_r | flags_r;
   end

   // ----------------------------------------------------------------
   // disable outputs
   // ----------------------------------------------------------------
   // overlap of one timer family only silences that family
   always_comb
   begin
      logic [NF-1:0] act;
      act = flags_r & enable_r[NF-1:0];
      mtu_off_nxt = (|act[poe_pkg::FLAG_CMP:0]) || act[poe_pkg::FLAG_MTU_OVL]
         || software_disable_request_reg_r;
      pwm_off_nxt = (|act[poe_pkg::FLAG_CMP:0]) || act[poe_pkg::FLAG_PWM_OVL]
         || software_disable_request_reg_r;
   end

   // registered release; targets stay off as long as an enabled flag for them is set
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         mtu_pin_release_r <= '0;
         pwm_pin_release_r <= '0;
      end
      else
      begin
         mtu_pin_release_r <= {MTU_PINS{mtu_off_nxt}};
         pwm_pin_release_r <= {PWM_PINS{pwm_off_nxt}};
      end
   end

   // interrupt requests follow the sticky flags
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         input_irq_r <= 1'b0;
         overlap_irq_r <= 1'b0;
      end
      else
      begin
         input_irq_r <= enable_r[poe_pkg::EN_IRQ_IN]
            && (|flags_r[NR-1:0]);
         overlap_irq_r <= enable_r[poe_pkg::EN_IRQ_OVL]
            && (flags_r[poe_pkg::FLAG_MTU_OVL]
                || flags_r[poe_pkg::FLAG_PWM_OVL]);
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // unmapped offsets read zero
   always_comb
   begin
      rdata_nxt = '0;
      case (addr)
         poe_pkg::REG_MODE_LO: rdata_nxt = mode_r[31:0];
         poe_pkg::REG_MODE_HI: rdata_nxt[3:0] = mode_r[4*NR-1:32];
         poe_pkg::REG_COUNT_SEL: rdata_nxt[2*NR-1:0] = cnt_sel_r;
         poe_pkg::REG_FLAGS: rdata_nxt[NF-1:0] = flags_r;
         poe_pkg::REG_ENABLE: rdata_nxt[poe_pkg::EN_W-1:0] = enable_r;
         poe_pkg::REG_SOFT: rdata_nxt[0] = software_disable_request_reg_r;
         poe_pkg::REG_STATUS:
         begin
            rdata_nxt[NR-1:0] = pins_n;
            rdata_nxt[poe_pkg::STAT_DISABLED] = mtu_pin_release_r[0]
               || pwm_pin_release_r[0];
            rdata_nxt[poe_pkg::STAT_OSC] = osc_stop_detected;
         end
         default: rdata_nxt = '0;
      endcase
   end

   // data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge clock)
   begin
      if (rst)
         rdata_r <= '0;
      else if (rd)
         rdata_r <= rdata_nxt;
      else
         rdata_r <= '0;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // an enable write in the same cycle may legally mask the source
   sequence s_osc_fault;
      osc_stop_detected && enable_r[poe_pkg::FLAG_OSC]
         && !(wr && addr == poe_pkg::REG_ENABLE);
   endsequence
   sequence s_both_off;
      mtu_pin_release_r[0] && pwm_pin_release_r[0];
   endsequence

   chk_osc_disables: assert property (@(posedge clock)
      disable iff (rst) s_osc_fault |=> ##1 s_both_off)
      else $error("oscillator stop did not disable outputs");
   chk_cmp_disables: assert property (@(posedge clock)
      disable iff (rst)
      (analog_comparator_unit_detect && enable_r[poe_pkg::FLAG_CMP]
       && !(wr && addr == poe_pkg::REG_ENABLE)) |=> ##1 s_both_off)
      else $error("comparator detection did not disable outputs");
   chk_mtu_overlap: assert property (@(posedge clock)
      disable iff (rst)
      (|(mtu_pair_a & mtu_pair_b) && enable_r[poe_pkg::FLAG_MTU_OVL]
       && !(wr && addr == poe_pkg::REG_ENABLE))
      |=> ##1 mtu_pin_release_r[0])
      else $error("timer pair overlap did not disable outputs");
   chk_pwm_overlap: assert property (@(posedge clock)
      disable iff (rst)
      (|(pwm_out_a & pwm_out_b) && enable_r[poe_pkg::FLAG_PWM_OVL]
       && !(wr && addr == poe_pkg::REG_ENABLE))
      |=> ##1 pwm_pin_release_r[0])
      else $error("pwm channel overlap did not disable outputs");
   chk_soft_disable: assert property (@(posedge clock)
      disable iff (rst) software_disable_request_reg_r |=> s_both_off)
      else $error("software request did not disable outputs");
   chk_input_disable: assert property (@(posedge clock)
      disable iff (rst)
      (det[0] && enable_r[0] && !(wr && addr == poe_pkg::REG_ENABLE))
      |=> ##1 (s_both_off and input_irq_r == enable_r[poe_pkg::EN_IRQ_IN]))
      else $error("request input did not disable outputs");
   chk_set_wins: assert property (@(posedge clock)
      disable iff (rst) (set_ev[0] && wr_flags && !wdata[0]) |=> flags_r[0])
      else $error("flag event lost to a clear");
   chk_low_clear: assert property (@(posedge clock)
      disable iff (rst)
      (flags_r[0] && poe_pkg::is_low_mode(mode_r[3:0]) && !pins_n[0])
      |=> flags_r[0])
      else $error("low-level flag cleared while pin low");
   chk_hold_off: assert property (@(posedge clock)
      disable iff (rst)
      (flags_r[poe_pkg::FLAG_OSC] && enable_r[poe_pkg::FLAG_OSC])[*2]
      |-> s_both_off)
      else $error("outputs re-enabled while flag still set");
   chk_read_slot: assert property (@(posedge clock)
      disable iff (rst) !rd |=> rdata_r == '0)
      else $error("read data outside its slot");
endmodule : port_output_disable_control

// [fault_source_model.sv]
// far-side model: fault request pins and watched timer outputs
`timescale 1ns/1ps
module fault_source_model
(
   // clock
   input wire logic clock,
   // scenario commands
   input wire logic [8:0] req_low,
   input wire logic [5:0] mtu_ovl,
   input wire logic [8:0] pwm_ovl,
   // fault request pins, active low
   output logic [8:0] req_n,
   // watched timer outputs, active high
   output logic [5:0] mtu_a,
   output logic [5:0] mtu_b,
   output logic [8:0] pwm_a,
   output logic [8:0] pwm_b
);
   logic [31:0] rnd;

   // pins idle high through the pull-up until a fault is staged
   assign req_n = ~req_low;
   // random complementary drive, overlap only when a scenario asks
   always @(posedge clock)
   begin
      rnd = $urandom;
      mtu_a <= rnd[5:0] | mtu_ovl;
      mtu_b <= ~rnd[5:0] | mtu_ovl;
      pwm_a <= rnd[14:6] | pwm_ovl;
      pwm_b <= ~rnd[14:6] | pwm_ovl;
   end
endmodule : fault_source_model

// [test_port_output_disable_control.sv]
// self-checking bench for the output-disable unit
`timescale 1ns/1ps
module test_port_output_disable_control;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int DIVS[6] = '{8, 16, 128, 1, 2, 4};
   localparam int CNTS[3] = '{16, 8, 4};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, osc = 1'b0, cmp = 1'b0;
   logic [31:0] rdata;
   logic [8:0] req_low = 9'h000, req_n, pwm_ovl = 9'h000, pwm_a, pwm_b;
   logic [5:0] mtu_ovl = 6'h00, mtu_a, mtu_b;
   logic [19:0] mtu_rel, pwm_rel;
   logic in_irq, ovl_irq;
   logic [31:0] exp_q[$];
   int n_mismatch = 0, checks_done = 0, i, j, n, dv;

   // ----------------------------------------------------------------
   // instances
   // ----------------------------------------------------------------
   port_output_disable_control DUT (.clock(clock), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata),
      .fault_request_in_0_n(req_n[0]), .fault_request_in_4_n(req_n[1]),
      .fault_request_in_8_n(req_n[2]), .fault_request_in_9_n(req_n[3]),
      .fault_request_in_10_n(req_n[4]), .fault_request_in_11_n(req_n[5]),
      .fault_request_in_12_n(req_n[6]), .fault_request_in_13_n(req_n[7]),
      .fault_request_in_14_n(req_n[8]), .osc_stop_detected(osc),
      .analog_comparator_unit_detect(cmp), .mtu_pair_a(mtu_a),
      .mtu_pair_b(mtu_b), .pwm_out_a(pwm_a), .pwm_out_b(pwm_b),
      .mtu_pin_release_r(mtu_rel), .pwm_pin_release_r(pwm_rel),
      .input_irq_r(in_irq), .overlap_irq_r(ovl_irq));
   fault_source_model far (.clock(clock), .req_low(req_low),
      .mtu_ovl(mtu_ovl), .pwm_ovl(pwm_ovl), .req_n(req_n), .mtu_a(mtu_a),
      .mtu_b(mtu_b), .pwm_a(pwm_a), .pwm_b(pwm_b));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_v

   task automatic wt(input int c);
      repeat (c) @(posedge clock);
   endtask : wt

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   // expected value is noted now, compared when the data stand
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      rd <= 1'b0;
   endtask : rd_reg

   // release buses are sampled mid-cycle, clear of the edge
   task automatic rel(input logic m, input logic p);
      @(negedge clock);
      cmp_v(32'(mtu_rel), 32'({20{m}}));
      cmp_v(32'(pwm_rel), 32'({20{p}}));
   endtask : rel

   // the clear needs a read that shows the flag first
   task automatic clr(input logic [31:0] f);
      rd_reg(8'h0C, f);
      wr_reg(8'h0C, ~f);
   endtask : clr

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------
   // clock, read monitor, watchdog
   // ----------------------------------------------------------------
   initial forever #12.5 clock = ~clock;
   // read data stand only in the cycle after the strobe
   always @(posedge clock) rd_d <= rd;
   always @(negedge clock)
      if (rd_d)
         cmp_v(rdata, exp_q.pop_front());
   // whole run is well under 15000 cycles
   initial
   begin
      wt(40000);
      n_mismatch++;
      test_done;
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial
   begin
      i = $urandom(32'h953B);
      wt(6);
      rst <= 1'b0;
      rd_reg(8'h10, 32'h1FFF);
      rd_reg(8'h00, 32'h0);
      rd_reg(8'h1C, 32'h0);
      wr_reg(8'h10, 32'h7FFF);
      // falling edge on every request input
      for (i = 0; i < 9; i++)
      begin
         wt(1);
         req_low <= 9'(1 << i);
         wt(4);
         rel(1'b1, 1'b1);
         cmp_v(32'(in_irq), 32'h1);
         @(posedge clock);
         req_low <= 9'h000;
         clr(32'(1 << i));
         wt(3);
         rel(1'b0, 1'b0);
      end
      // an event in the very cycle of its own clear keeps the flag
      wt(1);
      req_low <= 9'h001;
      wt(2);
      req_low <= 9'h000;
      rd_reg(8'h0C, 32'h1);
      req_low <= 9'h001;
      wr_reg(8'h0C, 32'hFFFF_FFFE);
      rd_reg(8'h0C, 32'h1);
      req_low <= 9'h000;
      clr(32'h1);
      // every low-level mode, every sample count
      for (i = 1; i < 7; i++)
      begin
         dv = DIVS[i - 1];
         n = CNTS[i % 3];
         wr_reg(8'h08, 32'(i % 3));
         wr_reg(8'h00, 32'(i));
         req_low <= 9'h001;
         wt((n - 1) * dv);
         req_low <= 9'h000;
         rd_reg(8'h0C, 32'h0);
         req_low <= 9'h001;
         wt((n + 1) * dv + 4);
         clr(32'h1);
         rd_reg(8'h0C, 32'h1);
         req_low <= 9'h000;
         clr(32'h1);
         rd_reg(8'h0C, 32'h0);
      end
      // prohibited code detects nothing
      wr_reg(8'h00, 32'h7);
      req_low <= 9'h001;
      wt(40);
      req_low <= 9'h000;
      rd_reg(8'h0C, 32'h0);
      wr_reg(8'h00, 32'h0);
      // oscillator stop, then comparator, each for one cycle
      for (i = 0; i < 2; i++)
      begin
         wt(1);
         {cmp, osc} <= 2'(1 << i);
         wt(1);
         {cmp, osc} <= 2'b00;
         wt(3);
         rel(1'b1, 1'b1);
         clr(32'(1 << (9 + i)));
         wt(3);
         rel(1'b0, 1'b0);
      end
      // masked source sets its flag but releases nothing
      wr_reg(8'h10, 32'h7DFF);
      osc <= 1'b1;
      wt(1);
      osc <= 1'b0;
      wt(3);
      rel(1'b0, 1'b0);
      clr(32'h200);
      wr_reg(8'h10, 32'h7FFF);
      // one-cycle overlap on a random pair, then a random channel
      j = $urandom % 6;
      n = $urandom % 9;
      mtu_ovl <= 6'(1 << j);
      wt(1);
      mtu_ovl <= 6'h00;
      wt(4);
      rel(1'b1, 1'b0);
      cmp_v(32'(ovl_irq), 32'h1);
      clr(32'h800);
      pwm_ovl <= 9'(1 << n);
      wt(1);
      pwm_ovl <= 9'h000;
      wt(4);
      rel(1'b0, 1'b1);
      clr(32'h1000);
      // software request, read-only status
      wt(3);
      wr_reg(8'h14, 32'h1);
      wt(2);
      rel(1'b1, 1'b1);
      rd_reg(8'h18, 32'h3FF);
      wr_reg(8'h18, 32'h0);
      rd_reg(8'h18, 32'h3FF);
      wr_reg(8'h14, 32'h0);
      wt(3);
      rel(1'b0, 1'b0);
      rd_reg(8'h18, 32'h1FF);
      wt(2);
      test_done;
   end
endmodule : test_port_output_disable_control
